// *** rtl/hwdg_pkg.sv ***
// Purpose: Constants for the host bus watchdog and protection outputs
// Assumes: 125 MHz system clock
// Notes on behaviour
// (RL1) Guard idle standalone; armed while any of six host-control bits is set.
// (RL2) Armed and no bus traffic for the full period raises timeout.
// (RL3) Only start plus matching slave address restarts count; host must keep talking.
// (RL4) Timeout forces balance and power switches off and resets serial logic.
// (RL5) While timed out, alert output pulses once per second.
// (RL6) Otherwise normal operation, switches held off until traffic resumes.
// (RL7) On resume clear scan, current, load, switch, nvm bits; keep balance bit.
// (RL8) On resume forced-off releases; switches follow other enabling conditions.
// (RL9) Switch turn-off applies gate pull-down as one 300 us pulse.
// (RL10) Fault output low while any cell or pack failure, high when all clear.
// (RL11) Charge-done low when all cells above 12-bit threshold, high when all below.
// (RL12) Fuse-blow output high while overvoltage lockout flag is set.
// (RL13) Optionally fuse-blow also on imbalance fault or open-wire condition.
// (RL14) Force-off input high turns off all power and balance switches.
// (RL15) Host balance bit disables automatic balancing, host drives balance outputs.
// (RL16) Nvm access select clear directs register access to shadow RAM.
// (RL17) Guard timeout length is a parameter counted in clock ticks.
package hwdg_pkg;
	localparam int          HWDG_CLK_HZ       = 125000000;
	localparam int          HWDG_ALERT_US     = 1000000;
	localparam int          HWDG_ALERT_CYC    = HWDG_CLK_HZ / 1000000 * HWDG_ALERT_US;
	localparam int          HWDG_ALERT_LEN    = 8;
	localparam int          HWDG_PULLDN_US    = 300;
	localparam int          HWDG_PULLDN_CYC   = (HWDG_CLK_HZ / 1000000) * HWDG_PULLDN_US;
	localparam int          HWDG_TIMEOUT_CYC  = 125000000;
	localparam int          HWDG_CNT_W        = 32;
	localparam int          HWDG_CELLS        = 8;
	localparam int          HWDG_VOLT_W       = 12;
	localparam int          HWDG_SWITCHES     = 3;
	localparam logic [6:0]  HWDG_SLAVE_ADDR   = 7'h28;
	typedef enum logic [1:0] {HWDG_IDLE, HWDG_ARMED, HWDG_TIMEOUT} hwdg_state_t;
endpackage

// *** rtl/hwdg_top.sv ***
// Purpose: Bus inactivity guard and digital protection outputs
// Assumes: Serial lines sampled by clk_sys_in; slave address low bit from pin
// Notes: Host-control bits are held here; their writes come as set/clear strobes
`timescale 1ns/1ps
`default_nettype none
module hwdg_top
	import hwdg_pkg::*;
#(
	// (RL17) Guard period in clock ticks
	parameter int TIMEOUT_CYC = HWDG_TIMEOUT_CYC,
	parameter int ALERT_CYC   = HWDG_ALERT_CYC,
	parameter int PULLDN_CYC  = HWDG_PULLDN_CYC
) (
	input  wire logic                              clk_sys_in,
	input  wire logic                              rstn_in,
	input  wire logic                              scl_in,
	input  wire logic                              sda_in,
	input  wire logic                              addr_sel_in,
	input  wire logic [5:0]                        host_bits_set_in,
	input  wire logic [5:0]                        host_bits_clr_in,
	input  wire logic [HWDG_SWITCHES-1:0]          auto_switch_en_in,
	input  wire logic [HWDG_CELLS-1:0]             auto_balance_in,
	input  wire logic [HWDG_SWITCHES-1:0]          host_switch_in,
	input  wire logic [HWDG_CELLS-1:0]             host_balance_in,
	input  wire logic [HWDG_CELLS*HWDG_VOLT_W-1:0] cell_volt_in,
	input  wire logic [HWDG_VOLT_W-1:0]            eoc_thresh_in,
	input  wire logic [4:0]                        fault_flags_in,
	input  wire logic                              cell_overvoltage_lockout_in,
	input  wire logic                              cell_imbalance_fault_in,
	input  wire logic                              open_wire_in,
	input  wire logic                              fuse_opt_en_in,
	input  wire logic                              force_switch_off_in,
	output logic                                   host_scan_ctrl_out,
	output logic                                   host_current_monitor_ctrl_out,
	output logic                                   host_load_monitor_ctrl_out,
	output logic                                   host_balance_ctrl_out,
	output logic                                   host_switch_ctrl_out,
	output logic                                   nvm_access_select_out,
	output logic                                   nvm_target_out,
	output logic                                   serial_reset_out,
	output logic                                   timeout_out,
	output logic                                   alert_n_out,
	output logic [HWDG_SWITCHES-1:0]               power_switch_out,
	output logic [HWDG_SWITCHES-1:0]               pulldown_out,
	output logic [HWDG_CELLS-1:0]                  balance_out,
	output logic                                   fault_out_n_out,
	output logic                                   fault_out_n_oe_out,
	output logic                                   charge_done_n_out,
	output logic                                   charge_done_n_oe_out,
	output logic                                   fuse_blow_out
);
	////////////////////////////////////////////////////////////////////////////
	logic rst_s1_q, rstn_q;
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_s1_q <= 1'b0;
			rstn_q   <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rstn_q   <= rst_s1_q;
		end
	end

	// Pin synchronisers; only stage two is read
	logic [2:0] sy1_q, sy2_q;
	logic       scl_d1_q, sda_d1_q;
	always_ff @(posedge clk_sys_in or negedge rstn_q) begin
		if (!rstn_q) begin
			sy1_q    <= 3'h7;
			sy2_q    <= 3'h7;
			scl_d1_q <= 1'b1;
			sda_d1_q <= 1'b1;
		end else begin
			sy1_q    <= {force_switch_off_in, scl_in, sda_in};
			sy2_q    <= sy1_q;
			scl_d1_q <= sy2_q[1];
			sda_d1_q <= sy2_q[0];
		end
	end
	wire force_off_s = sy2_q[2];
	wire scl_s       = sy2_q[1];
	wire sda_s       = sy2_q[0];
	wire scl_rise    = scl_s && !scl_d1_q;
	wire start_det   = scl_s && scl_d1_q && sda_d1_q && !sda_s;
	wire stop_det    = scl_s && scl_d1_q && !sda_d1_q && sda_s;

	////////////////////////////////////////////////////////////////////////////
	// Slave byte catcher: 8 bits after start, compared on the eighth edge
	logic [7:0] sh_q;
	logic [3:0] bit_q;
	logic       hunt_q;
	wire [6:0]  own_addr  = {HWDG_SLAVE_ADDR[6:1], addr_sel_in};
	wire        byte_done = hunt_q && scl_rise && (bit_q == 4'h7);
	// (RL3) Start plus own address
	wire        addr_hit  = byte_done && ({sh_q[6:0], sda_s} >> 1) == {1'b0, own_addr};
	always_ff @(posedge clk_sys_in or negedge rstn_q) begin
		if (!rstn_q) begin
			sh_q   <= 8'h00;
			bit_q  <= 4'h0;
			hunt_q <= 1'b0;
		end else if (start_det) begin
			bit_q  <= 4'h0;
			hunt_q <= 1'b1;
		end else if (stop_det || byte_done) begin
			hunt_q <= 1'b0;
		end else if (hunt_q && scl_rise) begin
			sh_q  <= {sh_q[6:0], sda_s};
			bit_q <= bit_q + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	hwdg_state_t st_q, st_d;
	logic [5:0]  hb_q;
	logic [HWDG_CNT_W-1:0] wcnt_q, acnt_q;
	// (RL1) Arm on any host bit
	wire armed_req = |hb_q;
	// (RL2) Full period elapsed
	wire expired   = wcnt_q >= HWDG_CNT_W'(TIMEOUT_CYC - 1);
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			HWDG_IDLE:    if (armed_req) st_d = HWDG_ARMED;
			HWDG_ARMED:   if (!armed_req) st_d = HWDG_IDLE;
			              else if (!addr_hit && expired) st_d = HWDG_TIMEOUT;
			// (RL6) Held until traffic resumes
			HWDG_TIMEOUT: if (addr_hit) st_d = HWDG_ARMED;
			// Unused fourth code falls back to idle
			default:      st_d = HWDG_IDLE;
		endcase
	end
	wire in_to  = st_q == HWDG_TIMEOUT;
	// (RL7) Resume clears all but balance bit
	wire resume = in_to && addr_hit;
	wire [5:0] resume_clr = resume ? 6'h37 : 6'h00;
	always_ff @(posedge clk_sys_in or negedge rstn_q) begin
		if (!rstn_q) begin
			st_q   <= HWDG_IDLE;
			hb_q   <= 6'h00;
			wcnt_q <= '0;
			acnt_q <= '0;
		end else begin
			st_q   <= st_d;
			hb_q   <= (hb_q & ~host_bits_clr_in & ~resume_clr) | host_bits_set_in;
			// (RL3) Restart on own address
			wcnt_q <= (st_q != HWDG_ARMED || addr_hit) ? '0 : wcnt_q + 1'b1;
			// (RL5) One-second alert period
			acnt_q <= (!in_to || acnt_q == HWDG_CNT_W'(ALERT_CYC - 1)) ? '0 : acnt_q + 1'b1;
		end
	end
	assign {nvm_access_select_out, host_switch_ctrl_out, host_balance_ctrl_out,
		host_load_monitor_ctrl_out, host_current_monitor_ctrl_out, host_scan_ctrl_out} = hb_q;
	// (RL16) Clear selects shadow RAM
	assign nvm_target_out   = hb_q[5];
	assign timeout_out      = in_to;
	// (RL4) Serial logic reset
	assign serial_reset_out = in_to;
	assign alert_n_out      = !(in_to && acnt_q < HWDG_CNT_W'(HWDG_ALERT_LEN));

	////////////////////////////////////////////////////////////////////////////
	// (RL14) Force-off overrides all; (RL4) (RL8) timeout forcing
	wire kill = force_off_s || in_to;
	// (RL15) Host balance bit selects source
	wire [HWDG_CELLS-1:0] bal_src = hb_q[3] ? host_balance_in : auto_balance_in;
	wire [HWDG_SWITCHES-1:0] sw_src = hb_q[4] ? host_switch_in : auto_switch_en_in;
	wire [HWDG_SWITCHES-1:0] sw_d   = kill ? '0 : sw_src;
	logic [HWDG_CELLS-1:0] above, below;
	genvar gi;
	generate
		for (gi = 0; gi < HWDG_CELLS; gi++) begin : g_cell
			wire [HWDG_VOLT_W-1:0] v = cell_volt_in[gi*HWDG_VOLT_W +: HWDG_VOLT_W];
			assign above[gi] = v > eoc_thresh_in;
			assign below[gi] = v < eoc_thresh_in;
		end
	endgenerate
	logic [HWDG_SWITCHES-1:0] sw_q;
	logic [HWDG_CNT_W-1:0]    pd_q [HWDG_SWITCHES];
	logic                     eoc_q;
	generate
		for (gi = 0; gi < HWDG_SWITCHES; gi++) begin : g_sw
			// (RL9) Single 300 us pull-down
			always_ff @(posedge clk_sys_in or negedge rstn_q) begin
				if (!rstn_q)
					pd_q[gi] <= '0;
				else if (sw_q[gi] && !sw_d[gi])
					pd_q[gi] <= HWDG_CNT_W'(PULLDN_CYC);
				else if (pd_q[gi] != '0)
					pd_q[gi] <= pd_q[gi] - 1'b1;
			end
			assign pulldown_out[gi] = pd_q[gi] != '0;
		end
	endgenerate
	always_ff @(posedge clk_sys_in or negedge rstn_q) begin
		if (!rstn_q) begin
			sw_q          <= '0;
			balance_out   <= '0;
			eoc_q         <= 1'b0;
			fuse_blow_out <= 1'b0;
		end else begin
			sw_q          <= sw_d;
			balance_out   <= kill ? '0 : bal_src;
			// (RL11) Set all above, clear all below
			eoc_q         <= (&above) ? 1'b1 : ((&below) ? 1'b0 : eoc_q);
			// (RL12) (RL13) Fuse-blow sources
			fuse_blow_out <= cell_overvoltage_lockout_in
				|| (fuse_opt_en_in && (cell_imbalance_fault_in || open_wire_in));
		end
	end
	assign power_switch_out = sw_q;
	// (RL10) Fault pulls low
	assign fault_out_n_out      = 1'b0;
	assign fault_out_n_oe_out   = |fault_flags_in;
	assign charge_done_n_out    = 1'b0;
	assign charge_done_n_oe_out = eoc_q;
endmodule
`default_nettype wire

// *** tb/hwdg_host_model.sv ***
// Purpose: Bus master stand-in
// Assumes: Pulled-up lines, idle high
// Notes: Clock stands still between frames
`timescale 1ns/1ps
`default_nettype none
module hwdg_host_model (
	output logic scl_out,
	output logic sda_out
);
	initial {scl_out, sda_out} = 2'h3;
	task automatic send_addr(input logic [7:0] b);
		#3 sda_out = 0;
		#80;
		for (int i = 8; i >= 0; i--) begin
			scl_out = 0;
			#40 sda_out = (i > 0) ? b[i-1] : 1'b1;
			#40 scl_out = 1;
			#80;
		end
		scl_out = 0;
		#40 sda_out = 0;
		#40 scl_out = 1;
		#40 sda_out = 1;
		#80;
	endtask
endmodule
`default_nettype wire

// *** tb/hwdg_top_checker.sv ***
// Purpose: Port-level properties of the guard
// Assumes: Single clock domain
// Notes: Bound into every hwdg_top
`timescale 1ns/1ps
`default_nettype none
module hwdg_top_checker
	import hwdg_pkg::*;
(
	input wire logic       clk_sys_in, rstn_in, force_switch_off_in,
	input wire logic       cell_overvoltage_lockout_in, timeout_out, serial_reset_out,
	input wire logic       alert_n_out, fault_out_n_oe_out, fuse_blow_out,
	input wire logic       nvm_access_select_out, nvm_target_out, host_scan_ctrl_out,
	input wire logic       host_current_monitor_ctrl_out, host_load_monitor_ctrl_out,
	input wire logic       host_balance_ctrl_out, host_switch_ctrl_out,
	input wire logic [4:0] fault_flags_in,
	input wire logic [2:0] power_switch_out,
	input wire logic [7:0] balance_out
);
	wire logic [5:0] bits = {nvm_access_select_out, host_switch_ctrl_out, host_balance_ctrl_out,
		host_load_monitor_ctrl_out, host_current_monitor_ctrl_out, host_scan_ctrl_out};
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);
	a_idle_stays_quiet: assert property (bits == 0 && !timeout_out |=> !timeout_out)
		else $error("timeout while idle");
	a_timeout_forces_off: assert property (timeout_out |=> power_switch_out == 0 && balance_out == 0)
		else $error("switches on in timeout");
	a_serial_reset_follows: assert property (serial_reset_out == timeout_out)
		else $error("serial reset differs");
	a_alert_width: assert property ($fell(alert_n_out) |-> ##8 alert_n_out)
		else $error("alert pulse width");
	a_resume_clears_bits: assert property ($fell(timeout_out) |-> bits == {2'h0, $past(bits[3]), 3'h0})
		else $error("bits on resume");
	a_force_off: assert property (force_switch_off_in [*4] |-> power_switch_out == 0 && balance_out == 0)
		else $error("force off ignored");
	a_fault_drive: assert property (fault_out_n_oe_out == |fault_flags_in)
		else $error("fault output");
	a_fuse_on_lockout: assert property (cell_overvoltage_lockout_in |=> fuse_blow_out)
		else $error("fuse not driven");
	a_nvm_target: assert property (nvm_target_out == nvm_access_select_out)
		else $error("nvm target");
endmodule
bind hwdg_top hwdg_top_checker i_chk (.*);
`default_nettype wire

// *** tb/hwdg_top_bench.sv ***
// Purpose: Self-checking bench for hwdg_top
// Assumes: Short counts via parameters
// Notes: Seeded random protection inputs
`timescale 1ns/1ps
`default_nettype none
module hwdg_top_bench;
	import hwdg_pkg::*;
	localparam int TO = 600, AL = 100, PD = 20;
	wire logic scl_in, sda_in;
	logic clk_sys_in, rstn_in, addr_sel_in, fuse_opt_en_in, force_switch_off_in, cd;
	logic cell_overvoltage_lockout_in, cell_imbalance_fault_in, open_wire_in, alert_n_out;
	logic [5:0] host_bits_set_in, host_bits_clr_in;
	logic [2:0] auto_switch_en_in, host_switch_in, power_switch_out, pulldown_out;
	logic [7:0] auto_balance_in, host_balance_in, balance_out;
	logic [95:0] cell_volt_in;
	logic [11:0] eoc_thresh_in;
	logic [4:0] fault_flags_in;
	logic host_scan_ctrl_out, host_current_monitor_ctrl_out, host_load_monitor_ctrl_out;
	logic host_balance_ctrl_out, host_switch_ctrl_out, nvm_access_select_out, nvm_target_out;
	logic serial_reset_out, timeout_out, fault_out_n_out, fault_out_n_oe_out, fuse_blow_out;
	logic charge_done_n_out, charge_done_n_oe_out;
	int fails = 0, samples_checked = 0, cyc = 0, n, lo;
	hwdg_top #(.TIMEOUT_CYC(TO), .ALERT_CYC(AL), .PULLDN_CYC(PD)) i_dut (.*);
	hwdg_host_model i_host (.scl_out(scl_in), .sda_out(sda_in));
	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys_in);
		#1;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("fails=%0d samples_checked=%0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	function automatic logic [7:0] own(input logic rw);
		return {6'h14, addr_sel_in, rw};
	endfunction
	// Hysteresis: hold between thresholds
	function automatic logic exp_cd(input logic prev);
		logic a = 1, b = 1;
		for (int c = 0; c < 8; c++) begin
			a &= cell_volt_in[c*12+:12] > eoc_thresh_in;
			b &= cell_volt_in[c*12+:12] < eoc_thresh_in;
		end
		return a ? 1'b1 : (b ? 1'b0 : prev);
	endfunction
	initial begin
		clk_sys_in = 0;
		forever #4 clk_sys_in = ~clk_sys_in;
	end
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 30000) begin
			fails++;
			finish_test();
		end
	end
	initial begin
		{rstn_in, fuse_opt_en_in, force_switch_off_in, host_bits_set_in, host_bits_clr_in} = '0;
		{cell_overvoltage_lockout_in, cell_imbalance_fault_in, open_wire_in, fault_flags_in} = '0;
		{cell_volt_in, eoc_thresh_in, cd} = '0;
		{auto_switch_en_in, host_switch_in} = 6'h2f;
		void'($urandom(32'h55fb));
		addr_sel_in = 1'($urandom);
		auto_balance_in = 8'($urandom);
		host_balance_in = 8'($urandom) | 8'h01;
		tick(3);
		rstn_in = 1;
		tick(TO + 20);
		chk(timeout_out, 0);
		host_bits_set_in = 6'h3f;
		tick(1);
		host_bits_set_in = 0;
		tick(3);
		chk({power_switch_out, balance_out}, {host_switch_in, host_balance_in});
		n = 4;
		while (timeout_out !== 1 && n < TO + 10) begin
			tick(1);
			n++;
		end
		chk(n >= TO && n <= TO + 4, 1);
		{n, lo} = '0;
		repeat (2 * AL) begin
			tick(1);
			n += pulldown_out[0];
			lo += !alert_n_out;
		end
		chk(n, PD);
		chk(lo, 16);
		chk({power_switch_out, balance_out}, 0);
		i_host.send_addr(own(0) ^ 8'h02);
		tick(5);
		chk(timeout_out, 1);
		i_host.send_addr(own(0));
		tick(5);
		chk({timeout_out, host_scan_ctrl_out, host_current_monitor_ctrl_out, host_load_monitor_ctrl_out,
			host_balance_ctrl_out, host_switch_ctrl_out, nvm_access_select_out}, 7'h04);
		chk({power_switch_out, balance_out}, {auto_switch_en_in, host_balance_in});
		repeat (4) i_host.send_addr(own(1));
		chk(timeout_out, 0);
		force_switch_off_in = 1;
		tick(5);
		chk({power_switch_out, balance_out}, 0);
		force_switch_off_in = 0;
		for (int i = 0; i < 24; i++) begin
			fault_flags_in = (i % 4 == 0) ? 5'h0 : 5'($urandom);
			{cell_overvoltage_lockout_in, cell_imbalance_fault_in, open_wire_in, fuse_opt_en_in} = 4'($urandom);
			for (int c = 0; c < 8; c++) cell_volt_in[c*12+:12] = 12'h800 + 12'($urandom_range(255));
			eoc_thresh_in = (i % 3 == 0) ? 12'h7ff : (i % 3 == 1) ? 12'h900 : 12'h880;
			tick(4);
			cd = exp_cd(cd);
			chk(fault_out_n_oe_out, |fault_flags_in);
			chk(charge_done_n_oe_out, cd);
			chk(fuse_blow_out, cell_overvoltage_lockout_in |
				(fuse_opt_en_in & (cell_imbalance_fault_in | open_wire_in)));
		end
		host_bits_set_in = 6'h20;
		tick(1);
		host_bits_set_in = 0;
		tick(3);
		chk(nvm_target_out, 1);
		host_bits_clr_in = 6'h20;
		tick(1);
		host_bits_clr_in = 0;
		tick(3);
		chk(nvm_target_out, 0);
		finish_test();
	end
endmodule
`default_nettype wire
